// >>> rtl/omc_pkg.sv
// Package for the operating mode controller: mode codes, control bit groups, timing counts.
// Assumes a single 25 MHz system clock domain.
package omc_pkg;
   // Clock rate and machine cycle length in basic clock periods.
   localparam int CLK_HZ = 25000000;
   localparam int MCYC_PERIODS = 4;
   localparam logic [1:0] MCYC_LAST = 2'h3;
   // Oscillator warm-up after stop release, in microseconds.
   localparam int WARMUP_US = 2000;
   localparam int WARMUP_CYC = (WARMUP_US * (CLK_HZ / 1000000) < 1) ? 1 :
      WARMUP_US * (CLK_HZ / 1000000);

   // Operating modes, one-hot.
   typedef enum logic [10:0] {
      OMC_NORMAL1 = 11'h001,
      OMC_IDLE1 = 11'h002,
      OMC_IDLE0 = 11'h004,
      OMC_NORMAL2 = 11'h008,
      OMC_IDLE2 = 11'h010,
      OMC_SLOW2 = 11'h020,
      OMC_SLEEP2 = 11'h040,
      OMC_SLOW1 = 11'h080,
      OMC_SLEEP1 = 11'h100,
      OMC_SLEEP0 = 11'h200,
      OMC_STOP = 11'h400
   } omc_mode_t;

   // Control bits written by software.
   typedef struct packed {
      logic fast_osc_enable;
      logic slow_osc_enable;
      logic main_clock_select;
      logic idle;
      logic periph_clock_halt;
      logic stop;
      logic stop_level_release;
      logic stop_return_slow;
   } omc_ctrl_t;

   // Clock gating and status presented to the rest of the chip.
   typedef struct packed {
      logic fast_osc_on;
      logic slow_osc_on;
      logic main_clk_slow;
      logic cpu_run;
      logic wdt_run;
      logic periph_clk_on;
      logic tbt_clk_on;
      logic div_low_on;
      logic slow_pins_are_port;
   } omc_gate_t;

   // Reset values of the control bits.
   localparam omc_ctrl_t CTRL_RST = '{fast_osc_enable: 1'b1, default: 1'b0};
endpackage

// >>> rtl/omc_ctrl.sv
// Operating mode controller: sequences run, idle, sleep and stop modes and gates clocks.
// Assumes software writes control bits by a one-cycle strobe and the CPU core
// stalls on cpu_run. Wake and stop pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module omc_ctrl #(
   parameter int WARMUP_CYCLES = omc_pkg::WARMUP_CYC
) (
   // Clock, reset and enable.
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Software control write.
   input wire logic ctrl_wr_i,
   input wire omc_pkg::omc_ctrl_t ctrl_i,
   // Interrupt side.
   input wire logic wake_req_i,
   input wire logic master_interrupt_enable_i,
   input wire logic time_base_individual_enable_i,
   input wire logic time_base_int_enable_i,
   input wire logic time_base_src_i,
   input wire logic stop_pin_i,
   // Status and gating.
   output omc_pkg::omc_mode_t mode_o,
   output omc_pkg::omc_ctrl_t ctrl_o,
   output omc_pkg::omc_gate_t gate_o,
   output logic [1:0] mcyc_state_o,
   output logic resume_take_int_o,
   output logic resume_next_insn_o,
   output logic time_base_interrupt_latch_set_o,
   output logic sw_reset_req_o
);
   omc_pkg::omc_mode_t mode_r;
   omc_pkg::omc_mode_t mode_nxt;
   omc_pkg::omc_ctrl_t ctrl_r;
   omc_pkg::omc_gate_t gate_r;
   logic [2:0] wake_sync_r;
   logic [2:0] tb_sync_r;
   logic [2:0] stop_sync_r;
   logic wake_q_r;
   logic tb_q_r;
   logic stop_q_r;
   logic tb_en_at_entry_r;
   logic stop_armed_r;
   logic [31:0] warm_cnt_r;
   logic warming_r;
   logic [1:0] mcyc_r;
   logic resume_take_int_r;
   logic resume_next_r;
   logic tb_set_r;
   logic sw_reset_r;
   logic wake_ev;
   logic tb_fall;
   logic stop_rel;
   logic bad_osc;

   // Agreed level of a three-stage synchroniser: second and third stage equal.
   function automatic logic sync_agree(input logic [2:0] s, input logic prev);
      return (s[1] == s[2]) ? s[2] : prev;
   endfunction

   // Synchronise asynchronous pins; only stages two and three are ever examined.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wake_sync_r <= 3'h0;
         tb_sync_r <= 3'h0;
         stop_sync_r <= 3'h0;
         wake_q_r <= 1'b0;
         tb_q_r <= 1'b0;
         stop_q_r <= 1'b0;
      end else if (ce_i) begin
         wake_sync_r <= {wake_sync_r[1:0], wake_req_i};
         tb_sync_r <= {tb_sync_r[1:0], time_base_src_i};
         stop_sync_r <= {stop_sync_r[1:0], stop_pin_i};
         wake_q_r <= sync_agree(wake_sync_r, wake_q_r);
         tb_q_r <= sync_agree(tb_sync_r, tb_q_r);
         stop_q_r <= sync_agree(stop_sync_r, stop_q_r);
      end
   end

   // Qualified events used by the mode machine.
   assign wake_ev = sync_agree(wake_sync_r, wake_q_r);
   assign tb_fall = tb_q_r & ~sync_agree(tb_sync_r, tb_q_r);
   // Level release needs the pin high; edge release needs a rising edge after arming.
   assign stop_rel = ctrl_r.stop_level_release ? stop_q_r :
      (stop_armed_r & stop_q_r);

   // Illegal oscillator combinations in a control write force a reset request.
   assign bad_osc = ctrl_wr_i &
      ((~ctrl_i.fast_osc_enable & ~ctrl_i.slow_osc_enable) |
       (~ctrl_i.fast_osc_enable & ~ctrl_r.main_clock_select) |
       (~ctrl_i.slow_osc_enable & ctrl_r.main_clock_select));

   // Next mode. Control writes only act from run modes; wakes from halted modes.
   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         omc_pkg::OMC_NORMAL1, omc_pkg::OMC_NORMAL2: begin
            if (ctrl_wr_i && ctrl_i.stop) begin
               mode_nxt = omc_pkg::OMC_STOP;
            end else if (ctrl_wr_i && ctrl_i.idle) begin
               mode_nxt = (mode_r == omc_pkg::OMC_NORMAL1) ? omc_pkg::OMC_IDLE1 :
                  omc_pkg::OMC_IDLE2;
            end else if (ctrl_wr_i && ctrl_i.periph_clock_halt) begin
               mode_nxt = omc_pkg::OMC_IDLE0;
            end else if (ctrl_wr_i && ctrl_i.slow_osc_enable && ctrl_i.main_clock_select) begin
               mode_nxt = omc_pkg::OMC_SLOW2;
            end else if (ctrl_wr_i && ctrl_i.slow_osc_enable) begin
               mode_nxt = omc_pkg::OMC_NORMAL2;
            end else if (ctrl_wr_i) begin
               mode_nxt = omc_pkg::OMC_NORMAL1;
            end
         end
         omc_pkg::OMC_SLOW2, omc_pkg::OMC_SLOW1: begin
            if (ctrl_wr_i && ctrl_i.stop) begin
               mode_nxt = omc_pkg::OMC_STOP;
            end else if (ctrl_wr_i && ctrl_i.idle) begin
               mode_nxt = (mode_r == omc_pkg::OMC_SLOW2) ? omc_pkg::OMC_SLEEP2 :
                  omc_pkg::OMC_SLEEP1;
            end else if (ctrl_wr_i && ctrl_i.periph_clock_halt) begin
               mode_nxt = omc_pkg::OMC_SLEEP0;
            end else if (ctrl_wr_i && !ctrl_i.main_clock_select && ctrl_i.fast_osc_enable) begin
               mode_nxt = omc_pkg::OMC_NORMAL2;
            end else if (ctrl_wr_i) begin
               mode_nxt = ctrl_i.fast_osc_enable ? omc_pkg::OMC_SLOW2 :
                  omc_pkg::OMC_SLOW1;
            end
         end
         omc_pkg::OMC_IDLE1: if (wake_ev) mode_nxt = omc_pkg::OMC_NORMAL1;
         omc_pkg::OMC_IDLE2: if (wake_ev) mode_nxt = omc_pkg::OMC_NORMAL2;
         omc_pkg::OMC_SLEEP1: if (wake_ev) mode_nxt = omc_pkg::OMC_SLOW1;
         omc_pkg::OMC_SLEEP2: if (wake_ev) mode_nxt = omc_pkg::OMC_SLOW2;
         omc_pkg::OMC_IDLE0: if (tb_fall) mode_nxt = omc_pkg::OMC_NORMAL1;
         omc_pkg::OMC_SLEEP0: if (tb_fall) mode_nxt = omc_pkg::OMC_SLOW1;
         omc_pkg::OMC_STOP: begin
            if (warming_r && warm_cnt_r == 32'h0) begin
               mode_nxt = ctrl_r.stop_return_slow ? omc_pkg::OMC_SLOW1 :
                  (ctrl_r.slow_osc_enable ? omc_pkg::OMC_NORMAL2 :
                   omc_pkg::OMC_NORMAL1);
            end
         end
         default: mode_nxt = omc_pkg::OMC_NORMAL1;
      endcase
   end

   // Mode register; a bad oscillator write resets to NORMAL1.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mode_r <= omc_pkg::OMC_NORMAL1;
      end else if (ce_i) begin
         mode_r <= bad_osc ? omc_pkg::OMC_NORMAL1 : mode_nxt;
      end
   end

   // Control bits. Idle and halt bits clear themselves on wake; a write in the same cycle
   // wins, so a fresh software request is never lost to the automatic clear.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_r <= omc_pkg::CTRL_RST;
      end else if (ce_i) begin
         if (bad_osc) begin
            ctrl_r <= omc_pkg::CTRL_RST;
         end else if (ctrl_wr_i) begin
            ctrl_r <= ctrl_i;
         end else if (mode_r != mode_nxt) begin
            ctrl_r.idle <= 1'b0;
            ctrl_r.periph_clock_halt <= 1'b0;
            ctrl_r.stop <= 1'b0;
         end
      end
   end

   // Stop release: arm edge detection once the pin is seen low, then count warm-up.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stop_armed_r <= 1'b0;
         warming_r <= 1'b0;
         warm_cnt_r <= 32'h0;
      end else if (ce_i) begin
         if (mode_r != omc_pkg::OMC_STOP) begin
            stop_armed_r <= 1'b0;
            warming_r <= 1'b0;
         end else if (!warming_r) begin
            if (!stop_q_r) stop_armed_r <= 1'b1;
            if (stop_rel) begin
               warming_r <= 1'b1;
               warm_cnt_r <= 32'(WARMUP_CYCLES - 1);
            end
         end else if (warm_cnt_r != 32'h0) begin
            warm_cnt_r <= warm_cnt_r - 32'h1;
         end
      end
   end

   // Capture the time base enable at halt entry and raise the latch set on return.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tb_en_at_entry_r <= 1'b0;
         tb_set_r <= 1'b0;
      end else if (ce_i) begin
         if (mode_nxt == omc_pkg::OMC_IDLE0 || mode_nxt == omc_pkg::OMC_SLEEP0) begin
            if (mode_r != mode_nxt) tb_en_at_entry_r <= time_base_int_enable_i;
         end
         tb_set_r <= tb_fall && tb_en_at_entry_r &&
            (mode_r == omc_pkg::OMC_IDLE0 || mode_r == omc_pkg::OMC_SLEEP0);
      end
   end

   // Resume style after an idle or sleep wake depends on the master enable.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         resume_take_int_r <= 1'b0;
         resume_next_r <= 1'b0;
         sw_reset_r <= 1'b0;
      end else if (ce_i) begin
         resume_take_int_r <= 1'b0;
         resume_next_r <= 1'b0;
         sw_reset_r <= bad_osc;
         if (mode_r inside {omc_pkg::OMC_IDLE1, omc_pkg::OMC_IDLE2,
                            omc_pkg::OMC_SLEEP1, omc_pkg::OMC_SLEEP2} && wake_ev) begin
            resume_take_int_r <= master_interrupt_enable_i;
            resume_next_r <= ~master_interrupt_enable_i;
         end else if ((mode_r == omc_pkg::OMC_IDLE0 || mode_r == omc_pkg::OMC_SLEEP0) && tb_fall) begin
            resume_take_int_r <= master_interrupt_enable_i & time_base_individual_enable_i &
               tb_en_at_entry_r;
            resume_next_r <= ~(master_interrupt_enable_i & time_base_individual_enable_i &
               tb_en_at_entry_r);
         end else if (mode_r == omc_pkg::OMC_STOP && mode_nxt != omc_pkg::OMC_STOP) begin
            resume_next_r <= 1'b1;
         end
      end
   end

   // Clock gating is registered from the next mode so it changes with the mode, except after a bad oscillator write, when it follows one cycle later.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         gate_r <= '{fast_osc_on: 1'b1, cpu_run: 1'b1, wdt_run: 1'b1, periph_clk_on: 1'b1,
                     tbt_clk_on: 1'b1, div_low_on: 1'b1, slow_pins_are_port: 1'b1,
                     default: 1'b0};
      end else if (ce_i) begin
         gate_r.fast_osc_on <= !(mode_nxt inside {omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLEEP1,
            omc_pkg::OMC_SLEEP0}) && !(mode_nxt == omc_pkg::OMC_STOP && !warming_r);
         gate_r.slow_osc_on <= !(mode_nxt inside {omc_pkg::OMC_NORMAL1, omc_pkg::OMC_IDLE1,
            omc_pkg::OMC_IDLE0, omc_pkg::OMC_STOP});
         gate_r.main_clk_slow <= mode_nxt inside {omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLOW2,
            omc_pkg::OMC_SLEEP0, omc_pkg::OMC_SLEEP1, omc_pkg::OMC_SLEEP2};
         gate_r.cpu_run <= mode_nxt inside {omc_pkg::OMC_NORMAL1, omc_pkg::OMC_NORMAL2,
            omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLOW2};
         gate_r.wdt_run <= mode_nxt inside {omc_pkg::OMC_NORMAL1, omc_pkg::OMC_NORMAL2,
            omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLOW2};
         gate_r.periph_clk_on <= !(mode_nxt inside {omc_pkg::OMC_IDLE0, omc_pkg::OMC_SLEEP0,
            omc_pkg::OMC_STOP});
         gate_r.tbt_clk_on <= mode_nxt != omc_pkg::OMC_STOP;
         gate_r.div_low_on <= !(mode_nxt inside {omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLEEP0,
            omc_pkg::OMC_SLEEP1, omc_pkg::OMC_SLEEP2, omc_pkg::OMC_STOP});
         gate_r.slow_pins_are_port <= mode_nxt inside {omc_pkg::OMC_NORMAL1,
            omc_pkg::OMC_IDLE1, omc_pkg::OMC_IDLE0};
      end
   end

   // Machine cycle phase counter; four basic clock periods per cycle while the CPU runs.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mcyc_r <= 2'h0;
      end else if (ce_i && gate_r.cpu_run) begin
         mcyc_r <= (mcyc_r == omc_pkg::MCYC_LAST) ? 2'h0 : mcyc_r + 2'h1;
      end
   end

   assign mode_o = mode_r;
   assign ctrl_o = ctrl_r;
   assign gate_o = gate_r;
   assign mcyc_state_o = mcyc_r;
   assign resume_take_int_o = resume_take_int_r;
   assign resume_next_insn_o = resume_next_r;
   assign time_base_interrupt_latch_set_o = tb_set_r;
   assign sw_reset_req_o = sw_reset_r;

   // Assertions.
   AST_RESET_NORMAL1: assert property (@(posedge mclk_i) $fell(rst_i) |->
      mode_r == omc_pkg::OMC_NORMAL1) else $error("not NORMAL1 after reset");
   AST_IDLE1_WAKE: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mode_r == omc_pkg::OMC_IDLE1 && wake_ev && !bad_osc) |=>
      mode_r == omc_pkg::OMC_NORMAL1 && !ctrl_r.idle) else $error("IDLE1 wake failed");
   AST_IDLE0_EXIT: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mode_r == omc_pkg::OMC_IDLE0 && tb_fall && !bad_osc) |=>
      mode_r == omc_pkg::OMC_NORMAL1) else $error("IDLE0 exit failed");
   AST_TB_LATCH: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mode_r == omc_pkg::OMC_SLEEP0 && tb_fall && tb_en_at_entry_r) |=>
      tb_set_r) else $error("time base latch not set");
   AST_SLOW2_TO_SLOW1: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mode_r == omc_pkg::OMC_SLOW2 && ctrl_wr_i && !bad_osc && !ctrl_i.stop &&
       !ctrl_i.idle && !ctrl_i.periph_clock_halt && ctrl_i.main_clock_select &&
       !ctrl_i.fast_osc_enable) |=> mode_r == omc_pkg::OMC_SLOW1)
      else $error("SLOW1 not entered");
   AST_BAD_OSC_RESET: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && bad_osc) |=> sw_reset_r && mode_r == omc_pkg::OMC_NORMAL1)
      else $error("oscillator reset missing");
   AST_DIV_STOPPED: assert property (@(posedge mclk_i) disable iff (rst_i)
      mode_r inside {omc_pkg::OMC_SLOW1, omc_pkg::OMC_SLEEP1} |-> !gate_r.div_low_on)
      else $error("divider low stages running");
   AST_IDLE0_GATES: assert property (@(posedge mclk_i) disable iff (rst_i)
      mode_r == omc_pkg::OMC_IDLE0 |-> !gate_r.periph_clk_on && gate_r.tbt_clk_on &&
      !gate_r.cpu_run) else $error("IDLE0 gating wrong");
   AST_IDLE_RESUME: assert property (@(posedge mclk_i) disable iff (rst_i)
      (ce_i && mode_r == omc_pkg::OMC_IDLE2 && wake_ev) |=>
      resume_take_int_r == $past(master_interrupt_enable_i) && resume_next_r != resume_take_int_r)
      else $error("resume style wrong");
   COV_IDLE1: cover property (@(posedge mclk_i) mode_r == omc_pkg::OMC_IDLE1 ##1
      mode_r == omc_pkg::OMC_NORMAL1);
   COV_SLEEP0: cover property (@(posedge mclk_i) mode_r == omc_pkg::OMC_SLEEP0 ##1
      mode_r == omc_pkg::OMC_SLOW1);
   COV_STOP: cover property (@(posedge mclk_i) mode_r == omc_pkg::OMC_STOP ##1
      mode_r != omc_pkg::OMC_STOP);
endmodule
`default_nettype wire

// >>> dv/omc_far_model.sv
// Far-side model: wake-up interrupt source, time base source clock and stop release pin.
// Assumes one-cycle go strobes from the bench and the controller's resume pulses.
`timescale 1ns/1ns
`default_nettype none
module omc_far_model (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Commands from the bench and acknowledge from the controller.
   input wire logic wake_go_i,
   input wire logic stop_go_i,
   input wire logic resume_i,
   // Lines seen by the controller.
   output logic wake_req_o,
   output logic time_base_src_o,
   output logic stop_pin_o
);
   logic [2:0] tb_div_r;
   // Requests stay up until the controller resumes, as a latched interrupt would.
   always_ff @(posedge mclk_i) begin
      if (rst_i || resume_i) begin
         wake_req_o <= 1'b0;
         stop_pin_o <= 1'b0;
      end else begin
         if (wake_go_i) wake_req_o <= 1'b1;
         if (stop_go_i) stop_pin_o <= 1'b1;
      end
   end
   // The time base source is a divider tap, so it runs free in every mode.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tb_div_r <= 3'h0;
         time_base_src_o <= 1'b0;
      end else begin
         tb_div_r <= tb_div_r + 3'h1;
         if (tb_div_r == 3'h7) time_base_src_o <= ~time_base_src_o;
      end
   end
endmodule
`default_nettype wire

// >>> dv/operating_mode_controller_tb_top.sv
// Testbench for the operating mode controller: walks every mode and the exit from each halted mode.
// Assumes the far-side model for wake, time base and stop lines; warm-up shortened to 4.
`timescale 1ns/1ns
`default_nettype none
module operating_mode_controller_tb_top;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ctrl_wr_i = 1'b0;
   omc_pkg::omc_ctrl_t ctrl_i = omc_pkg::CTRL_RST;
   omc_pkg::omc_ctrl_t cur = omc_pkg::CTRL_RST;
   logic master_interrupt_enable = 1'b0;
   logic tb_ind_en = 1'b1;
   logic tb_int_en = 1'b0;
   logic wake_go = 1'b0;
   logic stop_go = 1'b0;
   logic ce = 1'b1;
   logic wake_req, tb_src, stop_pin, take_int, next_insn, latch_set, sw_rst;
   logic seen_take, seen_next, seen_latch, seen_rst;
   logic [1:0] mcyc, v;
   omc_pkg::omc_mode_t mode;
   omc_pkg::omc_ctrl_t ctrl;
   omc_pkg::omc_gate_t gate;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   // Free-running 25 MHz clock.
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   omc_ctrl #(.WARMUP_CYCLES(4)) omc_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
      .ctrl_wr_i(ctrl_wr_i), .ctrl_i(ctrl_i), .wake_req_i(wake_req),
      .master_interrupt_enable_i(master_interrupt_enable), .time_base_individual_enable_i(tb_ind_en),
      .time_base_int_enable_i(tb_int_en), .time_base_src_i(tb_src), .stop_pin_i(stop_pin),
      .mode_o(mode), .ctrl_o(ctrl), .gate_o(gate), .mcyc_state_o(mcyc),
      .resume_take_int_o(take_int), .resume_next_insn_o(next_insn),
      .time_base_interrupt_latch_set_o(latch_set), .sw_reset_req_o(sw_rst));
   omc_far_model omc_far_model_inst (.mclk_i(mclk_i), .rst_i(rst_i), .wake_go_i(wake_go),
      .stop_go_i(stop_go), .resume_i(take_int | next_insn), .wake_req_o(wake_req),
      .time_base_src_o(tb_src), .stop_pin_o(stop_pin));
   // Pulses last one cycle, so they are caught in sticky flags; a hang ends the run.
   always @(posedge mclk_i) begin
      cycles = cycles + 1;
      if (take_int === 1'b1) seen_take = 1'b1;
      if (next_insn === 1'b1) seen_next = 1'b1;
      if (latch_set === 1'b1) seen_latch = 1'b1;
      if (sw_rst === 1'b1) seen_rst = 1'b1;
      if (cycles == 6000) begin
         err_count = err_count + 1;
         stop_test();
      end
   end
   task automatic clr();
      seen_take = 1'b0;
      seen_next = 1'b0;
      seen_latch = 1'b0;
      seen_rst = 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write strobe, launched and dropped on falling edges.
   task automatic wr(input omc_pkg::omc_ctrl_t c);
      @(negedge mclk_i);
      ctrl_i = c;
      ctrl_wr_i = 1'b1;
      @(negedge mclk_i);
      ctrl_wr_i = 1'b0;
   endtask
   task automatic wait_mode(input omc_pkg::omc_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 40) begin
         @(negedge mclk_i);
         n++;
      end
      check(mode, m);
   endtask
   // Idle-bit trip: halt, wake by interrupt request, check the resume style.
   task automatic idle_trip(input omc_pkg::omc_mode_t hm, input omc_pkg::omc_mode_t bm,
         input logic imf_v);
      // A request that was just withdrawn is still in the synchroniser for a few cycles.
      repeat (4) @(negedge mclk_i);
      master_interrupt_enable = imf_v;
      clr();
      cur.idle = 1'b1;
      wr(cur);
      cur.idle = 1'b0;
      check(mode, hm);
      check({gate.cpu_run, gate.wdt_run}, 2'h0);
      wake_go = 1'b1;
      @(negedge mclk_i);
      wake_go = 1'b0;
      @(negedge mclk_i);
      check(mode, hm);
      wait_mode(bm);
      @(negedge mclk_i);
      check(ctrl.idle, 1'b0);
      check(seen_take, imf_v);
      check(seen_next, !imf_v);
   endtask
   // Clock-halt trip: only the time base stays clocked until its falling edge.
   task automatic halt_trip(input omc_pkg::omc_mode_t hm, input omc_pkg::omc_mode_t bm,
         input logic en);
      tb_int_en = en;
      clr();
      cur.periph_clock_halt = 1'b1;
      wr(cur);
      cur.periph_clock_halt = 1'b0;
      tb_int_en = 1'b0; // The latch follows the enable seen at entry, not at exit.
      check(mode, hm);
      check({gate.cpu_run, gate.periph_clk_on, gate.tbt_clk_on}, 3'h1);
      wait_mode(bm);
      repeat (2) @(negedge mclk_i);
      check(seen_latch, en);
      check(gate.periph_clk_on, 1'b1);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence: reset, single-clock modes, dual-clock modes, bad write, stop.
   initial begin
      repeat (4) @(negedge mclk_i);
      rst_i = 1'b0;
      clr();
      check(mode, omc_pkg::OMC_NORMAL1);
      check(ctrl, omc_pkg::CTRL_RST);
      check(gate, 9'h13f);
      v = mcyc;
      repeat (4) begin
         @(negedge mclk_i);
         v = v + 2'h1;
         check(mcyc, v);
      end
      // A low clock enable must freeze the machine cycle phase.
      ce = 1'b0;
      repeat (3) @(negedge mclk_i);
      check(mcyc, v);
      ce = 1'b1;
      idle_trip(omc_pkg::OMC_IDLE1, omc_pkg::OMC_NORMAL1, 1'b1);
      idle_trip(omc_pkg::OMC_IDLE1, omc_pkg::OMC_NORMAL1, 1'b0);
      halt_trip(omc_pkg::OMC_IDLE0, omc_pkg::OMC_NORMAL1, 1'b1);
      halt_trip(omc_pkg::OMC_IDLE0, omc_pkg::OMC_NORMAL1, 1'b0);
      cur.slow_osc_enable = 1'b1; // Software starts the slow oscillator first.
      wr(cur);
      wait_mode(omc_pkg::OMC_NORMAL2);
      check({gate.slow_osc_on, gate.slow_pins_are_port}, 2'h2);
      idle_trip(omc_pkg::OMC_IDLE2, omc_pkg::OMC_NORMAL2, 1'b1);
      cur.main_clock_select = 1'b1;
      wr(cur);
      wait_mode(omc_pkg::OMC_SLOW2);
      check(gate.main_clk_slow, 1'b1);
      idle_trip(omc_pkg::OMC_SLEEP2, omc_pkg::OMC_SLOW2, 1'b0);
      cur.fast_osc_enable = 1'b0; // The slow enable is left alone here.
      wr(cur);
      wait_mode(omc_pkg::OMC_SLOW1);
      check({gate.fast_osc_on, gate.div_low_on}, 2'h0);
      idle_trip(omc_pkg::OMC_SLEEP1, omc_pkg::OMC_SLOW1, 1'b1);
      halt_trip(omc_pkg::OMC_SLEEP0, omc_pkg::OMC_SLOW1, 1'b1);
      cur.fast_osc_enable = 1'b1;
      wr(cur);
      wait_mode(omc_pkg::OMC_SLOW2);
      cur.main_clock_select = 1'b0;
      wr(cur);
      wait_mode(omc_pkg::OMC_NORMAL2);
      clr();
      cur.fast_osc_enable = 1'b0;
      wr(cur);
      wait_mode(omc_pkg::OMC_NORMAL1);
      @(negedge mclk_i);
      check(seen_rst, 1'b1);
      cur = omc_pkg::CTRL_RST;
      cur.stop = 1'b1;
      cur.stop_level_release = 1'b1;
      clr();
      wr(cur);
      check(mode, omc_pkg::OMC_STOP);
      check({gate.fast_osc_on, gate.cpu_run, gate.periph_clk_on}, 3'h0);
      stop_go = 1'b1;
      @(negedge mclk_i);
      stop_go = 1'b0;
      wait_mode(omc_pkg::OMC_NORMAL1);
      @(negedge mclk_i);
      check(seen_next, 1'b1);
      // Edge release: the pin is still seen high at entry, so only a new rise may release.
      cur.stop_level_release = 1'b0;
      clr();
      wr(cur);
      repeat (6) @(negedge mclk_i);
      check(mode, omc_pkg::OMC_STOP);
      stop_go = 1'b1;
      @(negedge mclk_i);
      stop_go = 1'b0;
      wait_mode(omc_pkg::OMC_NORMAL1);
      @(negedge mclk_i);
      check(seen_next, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
